/* step_link_cfg.svh */
// timing, field and offset constants for the one-pin step command link
`ifndef STEP_LINK_CFG_SVH
`define STEP_LINK_CFG_SVH

// ----------------------------------------------------------------
// clock and line timing
// ----------------------------------------------------------------
`define CLK_MHZ 40
`define T_START_US 2
`define END_OF_STREAM_TIME_US 2
`define T_ACK_MAX_US 512
`define T_VAL_US 2
`define T_ABORT_US 2000
`define T_HOST_VAL_US 4
`define START_CYC (`T_START_US * `CLK_MHZ)
`define EOS_CYC (`END_OF_STREAM_TIME_US * `CLK_MHZ)
`define ACK_CYC (`T_ACK_MAX_US * `CLK_MHZ)
`define VAL_CYC (`T_VAL_US * `CLK_MHZ)
`define ABORT_CYC (`T_ABORT_US * `CLK_MHZ)
`define HOST_VAL_CYC (`T_HOST_VAL_US * `CLK_MHZ)
`define SETTLE_CYC 4
`define CNT_W 18
`define UNIT_W 16
`define UNIT_RESET 16'h00c8

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DEV_ADDR_DEFAULT 8'h5a
`define BYTE_MSB 7
`define ACK_REQ_POS 7
`define SUB_HI_POS 6
`define SUB_LO_POS 5
`define STEP_MSB 4
`define STEP_RESET 5'h1f
`define LAST_BIT 3'h7

// ----------------------------------------------------------------
// host register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W 4
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define REG_UNIT 4'h8
`define ST_BUSY 0
`define ST_ACK 1
`define ST_DONE 2

`endif

/* step_link_pkg.sv */
// state types shared by both ends of the step command link
package step_link_pkg;

   typedef enum logic [2:0]
   {
      D_IDLE = 3'h0,
      D_BITS = 3'h1,
      D_GAP = 3'h3,
      D_VALID = 3'h5,
      D_ACK = 3'h4
   } dev_state_t;

   typedef enum logic [2:0]
   {
      H_IDLE = 3'h0,
      H_START = 3'h1,
      H_LOW = 3'h3,
      H_HIGH = 3'h2,
      H_EOS = 3'h6,
      H_VAL = 3'h7,
      H_SAMPLE = 3'h5,
      H_WAITHI = 3'h4
   } host_state_t;

endpackage

/* one_pin_if.sv */
// one shared control pin with pull-up, open-drain at both ends
`timescale 1ns/1ps
interface one_pin_if;
   logic host_do;
   logic host_oe;
   logic dev_do;
   logic dev_oe;
   logic line;

   // pulled high unless an enabled end drives a low
   assign line = ~((host_oe & ~host_do) | (dev_oe & ~dev_do));

   modport dev
   (
      input line,
      output dev_do,
      output dev_oe
   );

   modport host
   (
      input line,
      output host_do,
      output host_oe
   );
endinterface // one_pin_if

/* step_link_dev.sv */
// device end: decodes the two-byte frame, stores the step code, acknowledges
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "step_link_cfg.svh"

// Contract
// (RULE_01) bytes travel msb first, lsb last
// (RULE_02) data byte: ack flag, two zero subaddress, step
// (RULE_03) host holds line high 2 us before byte
// (RULE_04) address byte accepted without start condition
// (RULE_05) host ends each byte with 2 us end
// (RULE_06) one: high twice low; zero: low twice high
// (RULE_07) bit measured falling edge to falling edge
// (RULE_08) acknowledge only on request, address match, clean
// (RULE_09) acknowledge pulls line low at most 512 us
// (RULE_10) pull-down starts after fixed validation delay
// (RULE_11) host keeps line low during validation delay
// (RULE_12) host releases, reads low as acknowledge
// (RULE_13) host waits for acknowledge end before sending
// (RULE_14) only open-drain host may request acknowledge
// (RULE_15) push-pull host adds 500 uA series resistor
// (RULE_16) step code stored, full scale after reset
// (RULE_17) rate independent decoding, 1.7 to 160 kbit/s
// (RULE_18) bad frame leaves stored step code unchanged
module step_link_dev
   import step_link_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = `DEV_ADDR_DEFAULT, // arbitrary value
   parameter int ABORT_CYC = `ABORT_CYC,
   parameter int ACK_CYC = `ACK_CYC,
   parameter int VAL_CYC = `VAL_CYC
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   one_pin_if.dev link,
   output logic [`STEP_MSB:0] step_code_out,
   output logic step_load_out,
   output logic frame_err_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // (RULE_17) rate free: {valid, value} from the ratio alone
   function automatic logic [1:0] decide_bit(input logic [`CNT_W-1:0] hi,
                                             input logic [`CNT_W-1:0] lo);
      logic [`CNT_W:0] hi_w;
      logic [`CNT_W:0] lo_w;
      hi_w = {1'b0, hi};
      lo_w = {1'b0, lo};
      if (hi_w >= (lo_w << 1))
         decide_bit = 2'h3;
      else if (lo_w >= (hi_w << 1))
         decide_bit = 2'h2;
      else
         decide_bit = 2'h0;
   endfunction

   function automatic logic [`CNT_W-1:0] sat_inc(input logic [`CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + `CNT_W'(1);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dev_state_t state_q, state_d;
   logic line_q;
   logic [`CNT_W-1:0] hi_q, hi_d;
   logic [`CNT_W-1:0] lo_q, lo_d;
   logic [`CNT_W-1:0] per_q, per_d;
   logic [`CNT_W-1:0] tmr_q, tmr_d;
   logic [2:0] nbit_q, nbit_d;
   logic second_q, second_d;
   logic [7:0] shift_q, shift_d;
   logic addr_ok_q, addr_ok_d;
   logic bad_q, bad_d;
   logic [`STEP_MSB:0] step_q, step_d;
   logic load_d;
   logic err_d;
   logic pull_q, pull_d;
   logic do_q;

   // ----------------------------------------------------------------
   // line decoding
   // ----------------------------------------------------------------
   wire fall_w = line_q & ~link.line;
   wire [1:0] bit_w = decide_bit(hi_q, lo_q);
   // (RULE_01) msb first shift
   wire [7:0] shift_new_w = {shift_q[6:0], bit_w[0]};
   wire byte_end_w = (nbit_q == `LAST_BIT);
   wire timeout_w = (per_q >= `CNT_W'(ABORT_CYC));
   wire bad_new_w = bad_q | ~bit_w[1];
   // (RULE_02) field split of the data byte
   wire ack_req_w = shift_new_w[`ACK_REQ_POS];
   wire sub_zero_w = ~shift_new_w[`SUB_HI_POS] & ~shift_new_w[`SUB_LO_POS];
   // (RULE_18) store only a complete, addressed, clean frame
   wire frame_ok_w = addr_ok_q & ~bad_new_w & sub_zero_w;
   wire val_done_w = (tmr_q == `CNT_W'(VAL_CYC - 1));
   wire ack_done_w = (tmr_q == `CNT_W'(ACK_CYC - 1));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      hi_d = hi_q;
      lo_d = lo_q;
      per_d = sat_inc(per_q);
      tmr_d = tmr_q;
      nbit_d = nbit_q;
      second_d = second_q;
      shift_d = shift_q;
      addr_ok_d = addr_ok_q;
      bad_d = bad_q;
      step_d = step_q;
      load_d = 1'b0;
      err_d = 1'b0;
      pull_d = pull_q;
      unique case (state_q)
         // (RULE_04) any falling edge opens the address byte
         D_IDLE:
         begin
            per_d = '0;
            if (fall_w)
            begin
               state_d = D_BITS;
               hi_d = '0;
               lo_d = `CNT_W'(1);
               nbit_d = '0;
               second_d = 1'b0;
               bad_d = 1'b0;
               addr_ok_d = 1'b0;
            end
         end
         D_BITS:
         begin
            // (RULE_07) time low and high parts of one period
            if (link.line)
               hi_d = sat_inc(hi_q);
            else
               lo_d = sat_inc(lo_q);
            if (fall_w)
            begin
               // (RULE_06) decide; the edge sample is the first low one
               hi_d = '0;
               lo_d = `CNT_W'(1);
               per_d = '0;
               shift_d = shift_new_w;
               bad_d = bad_new_w;
               nbit_d = nbit_q + 3'h1;
               if (byte_end_w && !second_q)
               begin
                  addr_ok_d = (shift_new_w == DEV_ADDR);
                  state_d = D_GAP;
               end
               else if (byte_end_w)
               begin
                  if (frame_ok_w)
                  begin
                     // (RULE_16) keep the new step code
                     step_d = shift_new_w[`STEP_MSB:0];
                     load_d = 1'b1;
                  end
                  else
                     err_d = 1'b1;
                  tmr_d = '0;
                  // (RULE_08) acknowledge gate
                  state_d = (frame_ok_w && ack_req_w) ? D_VALID : D_IDLE;
               end
            end
            else if (timeout_w)
            begin
               // (RULE_18) a stalled frame is dropped
               err_d = 1'b1;
               state_d = D_IDLE;
            end
         end
         D_GAP:
         begin
            if (fall_w)
            begin
               state_d = D_BITS;
               hi_d = '0;
               lo_d = `CNT_W'(1);
               per_d = '0;
               nbit_d = '0;
               second_d = 1'b1;
            end
            else if (timeout_w)
            begin
               err_d = 1'b1;
               state_d = D_IDLE;
            end
         end
         D_VALID:
         begin
            tmr_d = tmr_q + `CNT_W'(1);
            // (RULE_10) pull-down only after the validation delay
            if (val_done_w)
            begin
               tmr_d = '0;
               pull_d = 1'b1;
               state_d = D_ACK;
            end
         end
         D_ACK:
         begin
            tmr_d = tmr_q + `CNT_W'(1);
            // (RULE_09) bounded acknowledge pulse
            if (ack_done_w)
            begin
               pull_d = 1'b0;
               state_d = D_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state_q <= D_IDLE;
         line_q <= 1'b0;
         hi_q <= '0;
         lo_q <= '0;
         per_q <= '0;
         tmr_q <= '0;
         nbit_q <= '0;
         second_q <= 1'b0;
         shift_q <= '0;
         addr_ok_q <= 1'b0;
         bad_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         line_q <= link.line;
         hi_q <= hi_d;
         lo_q <= lo_d;
         per_q <= per_d;
         tmr_q <= tmr_d;
         nbit_q <= nbit_d;
         second_q <= second_d;
         shift_q <= shift_d;
         addr_ok_q <= addr_ok_d;
         bad_q <= bad_d;
      end
   end

   // (RULE_16) full scale after reset
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         step_q <= `STEP_RESET;
         step_load_out <= 1'b0;
         frame_err_out <= 1'b0;
         pull_q <= 1'b0;
         do_q <= 1'b1;
      end
      else
      begin
         step_q <= step_d;
         step_load_out <= load_d;
         frame_err_out <= err_d;
         pull_q <= pull_d;
         do_q <= ~pull_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign step_code_out = step_q;
   // open-drain: enable only while pulling low
   assign link.dev_oe = pull_q;
   assign link.dev_do = do_q;

endmodule // step_link_dev

/* step_link_host.sv */
// host end: avalon-mm command registers driving the open-drain line
`timescale 1ns/1ps
`include "step_link_cfg.svh"

module step_link_host
   import step_link_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = `DEV_ADDR_DEFAULT, // arbitrary value
   parameter int HOST_VAL_CYC = `HOST_VAL_CYC
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [`ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   one_pin_if.host link
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // phase length in cycles minus one: short = unit, long = three units
   function automatic logic [`CNT_W-1:0] phase_len(input logic long_ph,
                                                   input logic [`UNIT_W-1:0] u);
      logic [`CNT_W-1:0] uw;
      uw = {2'h0, u};
      phase_len = (long_ph ? (uw + uw + uw) : uw) - `CNT_W'(1);
   endfunction

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   host_state_t st_q;
   logic wait_q;
   logic [`UNIT_W-1:0] unit_q;
   logic [7:0] data_q;
   logic [7:0] sh_q;
   logic [2:0] bitn_q;
   logic second_q;
   logic [`CNT_W-1:0] cnt_q;
   logic pull_q;
   logic ack_q;
   logic done_q;

   wire req_w = avs_read_in | avs_write_in;
   wire take_w = req_w & ~wait_q;
   wire busy_w = (st_q != H_IDLE);
   wire cmd_wr_w = take_w & avs_write_in & (avs_address_in == `REG_CMD) & ~busy_w;
   wire unit_wr_w = take_w & avs_write_in & (avs_address_in == `REG_UNIT);
   wire [31:0] status_w = {29'h0, done_q, ack_q, busy_w};
   wire [31:0] rd_w = (avs_address_in == `REG_STATUS) ? status_w :
                      (avs_address_in == `REG_UNIT) ? {16'h0, unit_q} :
                      (avs_address_in == `REG_CMD) ? {24'h0, data_q} : 32'h0;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wait_q <= 1'b1;
         avs_readdata_out <= 32'h0;
         unit_q <= `UNIT_RESET;
      end
      else
      begin
         wait_q <= ~(req_w & wait_q);
         if (req_w & wait_q)
            avs_readdata_out <= rd_w;
         if (unit_wr_w && avs_writedata_in[`UNIT_W-1:0] != '0)
            unit_q <= avs_writedata_in[`UNIT_W-1:0];
      end
   end

   assign avs_waitrequest_out = wait_q;

   // ----------------------------------------------------------------
   // line sequencer
   // ----------------------------------------------------------------
   wire cnt_end_w = (cnt_q == '0);
   wire cur_bit_w = sh_q[`BYTE_MSB];

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         st_q <= H_IDLE;
         data_q <= '0;
         sh_q <= '0;
         bitn_q <= '0;
         second_q <= 1'b0;
         cnt_q <= '0;
         pull_q <= 1'b0;
         ack_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         if (!cnt_end_w)
            cnt_q <= cnt_q - `CNT_W'(1);
         unique case (st_q)
            H_IDLE:
               if (cmd_wr_w)
               begin
                  data_q <= avs_writedata_in[7:0];
                  sh_q <= DEV_ADDR;
                  second_q <= 1'b0;
                  ack_q <= 1'b0;
                  done_q <= 1'b0;
                  // (RULE_03) start condition high time
                  cnt_q <= `CNT_W'(`START_CYC - 1);
                  st_q <= H_START;
               end
            H_START:
               if (cnt_end_w)
               begin
                  pull_q <= 1'b1;
                  bitn_q <= '0;
                  cnt_q <= phase_len(~cur_bit_w, unit_q);
                  st_q <= H_LOW;
               end
            H_LOW:
               if (cnt_end_w)
               begin
                  // (RULE_06) one: short low, long high
                  pull_q <= 1'b0;
                  cnt_q <= phase_len(cur_bit_w, unit_q);
                  st_q <= H_HIGH;
               end
            H_HIGH:
               if (cnt_end_w)
               begin
                  pull_q <= 1'b1;
                  // (RULE_01) next bit toward lsb
                  sh_q <= {sh_q[6:0], 1'b0};
                  bitn_q <= bitn_q + 3'h1;
                  if (bitn_q == `LAST_BIT)
                  begin
                     // (RULE_05) end of stream low time
                     cnt_q <= `CNT_W'(`EOS_CYC - 1);
                     st_q <= H_EOS;
                  end
                  else
                  begin
                     cnt_q <= phase_len(~sh_q[`BYTE_MSB-1], unit_q);
                     st_q <= H_LOW;
                  end
               end
            H_EOS:
               if (cnt_end_w && !second_q)
               begin
                  pull_q <= 1'b0;
                  sh_q <= data_q;
                  second_q <= 1'b1;
                  cnt_q <= `CNT_W'(`START_CYC - 1);
                  st_q <= H_START;
               end
               // (RULE_02) request flag sits in bit 7 of the data byte
               else if (cnt_end_w && data_q[`ACK_REQ_POS])
               begin
                  // (RULE_11) keep low through validation delay
                  cnt_q <= `CNT_W'(HOST_VAL_CYC - 1);
                  st_q <= H_VAL;
               end
               else if (cnt_end_w)
               begin
                  pull_q <= 1'b0;
                  st_q <= H_WAITHI;
               end
            H_VAL:
               if (cnt_end_w)
               begin
                  // (RULE_14) open-drain release lets the device answer
                  pull_q <= 1'b0;
                  cnt_q <= `CNT_W'(`SETTLE_CYC - 1);
                  st_q <= H_SAMPLE;
               end
            H_SAMPLE:
               if (cnt_end_w)
               begin
                  // (RULE_12) low read back means acknowledged
                  ack_q <= ~link.line;
                  st_q <= H_WAITHI;
               end
            H_WAITHI:
               // (RULE_13) no new frame until the line is free
               if (link.line)
               begin
                  done_q <= 1'b1;
                  st_q <= H_IDLE;
               end
            default:
               st_q <= H_IDLE;
         endcase
      end
   end

   assign link.host_oe = pull_q;
   assign link.host_do = 1'b0;

endmodule // step_link_host

/* step_link_chk.sv */
// concurrent checks on the shared pin between host and device ends
`timescale 1ns/1ps
`include "step_link_cfg.svh"
module step_link_chk
   import step_link_pkg::*;
#(
   parameter int VAL_CYC = `VAL_CYC,
   parameter int ACK_CYC = 200
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic host_do,
   input wire logic host_oe,
   input wire logic dev_do,
   input wire logic dev_oe,
   input wire logic line,
   input wire logic [`STEP_MSB:0] step_code_out,
   input wire logic step_load_out,
   input wire logic frame_err_out
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic [15:0] low_q;
   logic [15:0] ack_q;
   logic [15:0] since_q;
   wire since_top = (since_q == 16'hffff);
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         low_q <= 16'h0000;
         ack_q <= 16'h0000;
         since_q <= 16'hffff;
      end
      else
      begin
         low_q <= (line || dev_oe) ? 16'h0000 : low_q + 16'h0001;
         ack_q <= dev_oe ? ack_q + 16'h0001 : 16'h0000;
         since_q <= step_load_out ? 16'h0000 : (since_top ? since_q : since_q + 16'h0001);
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   chk_ack_pulls_low:
      assert property (dev_oe |-> !dev_do && !line) else $error("ack not pulling low");
   chk_ack_length:
      assert property ($fell(dev_oe) |-> ack_q == ACK_CYC) else $error("ack length wrong");
   chk_val_delay:
      assert property ($rose(dev_oe) |-> low_q >= VAL_CYC && low_q <= VAL_CYC + 3)
         else $error("ack start off delay");
   chk_host_holds_low:
      assert property ($rose(dev_oe) |-> host_oe) else $error("host released early");
   chk_ack_good_frame:
      assert property ($rose(dev_oe) |-> since_q <= VAL_CYC + 2) else $error("ack without store");
   chk_quiet_in_ack:
      assert property (dev_oe && !host_oe |=> !host_oe) else $error("host talks during ack");
   chk_host_open_drain:
      assert property (!host_do) else $error("host drives high");
   chk_code_on_load:
      assert property ($changed(step_code_out) |-> $past(step_load_out) or ##[0:1] step_load_out)
         else $error("step code changed without load");
   chk_pulse_single:
      assert property (step_load_out || frame_err_out |=> !(step_load_out || frame_err_out))
         else $error("result pulse too long");
   chk_reset_code:
      assert property ($rose(resetn_in) |-> step_code_out == `STEP_RESET && !dev_oe)
         else $error("reset values wrong");
   cover property ($rose(dev_oe));
   cover property (step_load_out);
   cover property (frame_err_out);
endmodule // step_link_chk

/* one_pin_step_command_link_bench.sv */
// bench: host and device ends over one pin, plus a device driven directly
`timescale 1ns/1ps
`include "step_link_cfg.svh"
module one_pin_step_command_link_bench;
   typedef struct {logic [7:0] cmd; logic [15:0] unit; logic [4:0] step; logic ack; int ld;} row_t;
   logic clk_in;
   logic resetn_in;
   logic [3:0] adr;
   logic rd;
   logic wr;
   logic [31:0] wd;
   logic [31:0] avs_rd;
   logic avs_wait;
   logic [4:0] code_a;
   logic [4:0] code_b;
   logic ld_a, er_a, ld_b, er_b;
   logic pl = 1'b1;
   logic mid_ok;
   logic [15:0] wbits;
   int n_errors = 0;
   int n_compared = 0;
   int nld_a = 0, ner_a = 0, ner_b = 0, nld_b = 0, lo = 0, hi = 0;
   row_t rows[6] = '{'{8'h15, 16'h0004, 5'h15, 1'b0, 1}, '{8'h8a, 16'h0004, 5'h0a, 1'b1, 1},
      '{8'ha0, 16'h0004, 5'h0a, 1'b0, 0}, '{8'h9f, 16'h0028, 5'h1f, 1'b1, 1},
      '{8'hc1, 16'h0028, 5'h1f, 1'b0, 0}, '{8'h00, 16'h0004, 5'h00, 1'b0, 1}};
   one_pin_if lk();
   one_pin_if lk2();
   step_link_host u_step_link_host (.clk_in(clk_in), .resetn_in(resetn_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(avs_rd), .avs_waitrequest_out(avs_wait), .link(lk.host));
   step_link_dev #(.ACK_CYC(200)) u_step_link_dev (
      .clk_in(clk_in), .resetn_in(resetn_in), .link(lk.dev), .step_code_out(code_a),
      .step_load_out(ld_a), .frame_err_out(er_a));
   // second device faces the bench, which breaks the line rules on purpose
   step_link_dev #(.ABORT_CYC(5000), .ACK_CYC(200), .VAL_CYC(8)) u_step_link_dev_2 (
      .clk_in(clk_in), .resetn_in(resetn_in), .link(lk2.dev), .step_code_out(code_b),
      .step_load_out(ld_b), .frame_err_out(er_b));
   step_link_chk u_step_link_chk (.clk_in(clk_in),
      .resetn_in(resetn_in), .host_do(lk.host_do), .host_oe(lk.host_oe), .dev_do(lk.dev_do),
      .dev_oe(lk.dev_oe), .line(lk.line), .step_code_out(code_a), .step_load_out(ld_a),
      .frame_err_out(er_a));
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // ----------------------------------------
   // wire monitor: decodes the host's bits on its own
   // ----------------------------------------
   always @(posedge clk_in)
   begin
      pl <= lk.line;
      nld_a += (ld_a === 1'b1);
      ner_a += (er_a === 1'b1);
      nld_b += (ld_b === 1'b1);
      ner_b += (er_b === 1'b1);
      if (pl && !lk.line)
      begin
         // a fall after a long idle opens a frame and closes nothing
         if (lo > 0 && hi < 500 && (hi >= 2 * lo || lo >= 2 * hi))
            wbits <= {wbits[14:0], hi >= 2 * lo};
         else if (lo > 0 && hi < 500)
            mid_ok <= mid_ok & (lo >= `EOS_CYC) & (hi >= `START_CYC);
         else
            mid_ok <= 1'b1;
         lo <= 1;
         hi <= 0;
      end
      else if (!lk.line)
         lo <= lo + 1;
      else
         hi <= hi + 1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task final_report;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task cmp_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
         n_errors++;
      end
   endtask
   task timeout;
      $display("CHECK FAILED wait expected answer seen none");
      n_errors++;
      final_report();
   endtask
   task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge clk_in);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_in);
         if (avs_wait === 1'b0)
            break;
      end
      if (i == 20)
         timeout();
      q = avs_rd;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task pull(input logic v, input int n);
      lk2.host_oe <= v;
      repeat (n) @(posedge clk_in);
   endtask
   // unit of 4 cycles with exactly the 2x ratio: the decoding boundary
   task send_byte(input logic [7:0] v, input int bad);
      for (int i = 7; i >= 0; i--)
      begin
         pull(1'b1, (v[i] && i != bad) ? 4 : 8 - 4 * (i == bad));
         pull(1'b0, (v[i] || i == bad) ? 8 - 4 * (i == bad) : 4);
      end
   endtask
   task frame2(input logic [7:0] a, input logic [7:0] d, input int bad);
      repeat (300) @(posedge clk_in);
      send_byte(a, 8);
      pull(1'b1, `EOS_CYC);
      pull(1'b0, `START_CYC);
      send_byte(d, bad);
      pull(1'b1, `EOS_CYC);
      pull(1'b0, 2);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [31:0] q;
      int k;
      int ld_tot;
      resetn_in = 1'b0;
      adr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wd = 32'h0000_0000;
      lk2.host_do = 1'b0;
      lk2.host_oe = 1'b0;
      ld_tot = 0;
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      cmp_val("code_a", `STEP_RESET, code_a);
      av(1'b0, `REG_UNIT, 32'h0000_0000, q);
      cmp_val("unit", `UNIT_RESET, q);
      av(1'b1, 4'hc, 32'hffff_ffff, q);
      av(1'b0, 4'hc, 32'h0000_0000, q);
      cmp_val("unmapped", 32'h0000_0000, q);
      av(1'b1, `REG_UNIT, 32'h0000_0000, q);
      av(1'b0, `REG_UNIT, 32'h0000_0000, q);
      cmp_val("unit zero", `UNIT_RESET, q);
      $display("test registers done");
      foreach (rows[i])
      begin
         repeat (600) @(posedge clk_in);
         av(1'b1, `REG_UNIT, rows[i].unit, q);
         av(1'b1, `REG_CMD, rows[i].cmd, q);
         for (k = 0; k < 400; k++)
         begin
            repeat (20) @(posedge clk_in);
            av(1'b0, `REG_STATUS, 32'h0000_0000, q);
            if (q[`ST_DONE] === 1'b1)
               break;
         end
         if (k == 400)
            timeout();
         ld_tot += rows[i].ld;
         cmp_val("step", rows[i].step, code_a);
         cmp_bit("ack", rows[i].ack, q[`ST_ACK]);
         cmp_bit("busy", 1'b0, q[`ST_BUSY]);
         cmp_val("wire", {`DEV_ADDR_DEFAULT, rows[i].cmd}, wbits);
         cmp_bit("gaps", 1'b1, mid_ok);
         cmp_val("loads", ld_tot, nld_a);
         cmp_val("errors", i + 1 - ld_tot, ner_a);
         $display("test row %0d done", i);
      end
      frame2(`DEV_ADDR_DEFAULT, 8'h83, 8);
      cmp_bit("ack low", 1'b0, lk2.line);
      cmp_val("code_b", 5'h03, code_b);
      repeat (300) @(posedge clk_in);
      cmp_bit("ack end", 1'b1, lk2.line);
      frame2(8'h33, 8'h8a, 8);
      cmp_bit("no ack", 1'b1, lk2.line);
      frame2(`DEV_ADDR_DEFAULT, 8'h84, 2);
      cmp_bit("bad bit", 1'b1, lk2.line);
      repeat (300) @(posedge clk_in);
      send_byte(`DEV_ADDR_DEFAULT, 8);
      pull(1'b1, `EOS_CYC);
      pull(1'b0, 5100);
      cmp_val("code_b kept", 5'h03, code_b);
      cmp_val("loads_b", 1, nld_b);
      cmp_val("errors_b", 3, ner_b);
      $display("test direct device done");
      resetn_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      cmp_val("reset a", `STEP_RESET, code_a);
      cmp_val("reset b", `STEP_RESET, code_b);
      resetn_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      $display("test reset done");
      final_report();
   end
endmodule // one_pin_step_command_link_bench
